// file: dv/tb_vcc_top.sv
// Self-checking testbench of the comparator control block
`timescale 1ns/1ps
module tb_vcc_top;
    logic                      core_clk = 1'b0;
    logic                      rst      = 1'b1;
    logic [7:0]                addr     = 8'h00;
    logic [15:0]               wdata    = 16'h0000;
    logic                      wr_en    = 1'b0;
    logic                      rd_en    = 1'b0;
    logic [15:0]               rdata;
    logic [11:0]               pos_level = 12'h000;
    logic                      analog_result;
    vcc_pkg::vcc_analog_ctrl_t analog_ctrl;
    logic                      comparator_pin_out;
    logic                      comparator_irq;
    logic                      irq;
    int                        miscompares = 0;
    int                        comparisons = 0;
    int                        cycles      = 0;

    vcc_top vcc_top_inst (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .analog_result(analog_result),
        .analog_ctrl(analog_ctrl), .comparator_pin_out(comparator_pin_out),
        .comparator_irq(comparator_irq), .irq(irq));
    vcc_analog_model vcc_analog_model_inst (.ctrl(analog_ctrl), .pos_level(pos_level),
        .result(analog_result));

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    // ==========================================================================
    // Bus and compare helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd
    task automatic drive_level(input logic [11:0] v);
        @(posedge core_clk);
        pos_level <= v;
        repeat (6) @(posedge core_clk);
        #1;
    endtask : drive_level

    // ==========================================================================
    // Scenarios
    task automatic t_reset;
        rd(vcc_pkg::ADDR_CONTROL, vcc_pkg::CONTROL_RESET);
        rd(vcc_pkg::ADDR_IRQ_STATUS, 16'h0000);
        rd(8'h3C, 16'h0000);
        wr(8'h3C, 16'hFFFF);
        rd(vcc_pkg::ADDR_CONTROL, 16'h0000);
    endtask : t_reset
    task automatic t_fields;
        logic [15:0] cfg [5];
        logic [4:0]  exp [5];
        cfg = '{16'hFFFF, 16'h0400, 16'h0418, 16'h0508, 16'h0604};
        exp = '{5'h1F, 5'h10, 5'h11, 5'h14, 5'h1A};
        for (int i = 0; i < 5; i++) begin
            wr(vcc_pkg::ADDR_CONTROL, cfg[i]);
            rd(vcc_pkg::ADDR_CONTROL, cfg[i] & 16'h07FC);
            chk({11'h000, analog_ctrl}, {11'h000, exp[i]});
        end
    endtask : t_fields
    task automatic t_edges(input logic pol);
        logic [15:0] cfg;
        cfg = 16'h0480 | (pol ? 16'h0020 : 16'h0000);
        wr(vcc_pkg::ADDR_CONTROL, cfg | 16'h0003);
        drive_level(12'hC00);
        chk({15'h0000, comparator_pin_out}, {15'h0000, ~pol});
        rd(vcc_pkg::ADDR_CONTROL, cfg | (pol ? 16'h0001 : 16'h0002));
        wr(vcc_pkg::ADDR_CONTROL, cfg);
        rd(vcc_pkg::ADDR_CONTROL, cfg | (pol ? 16'h0001 : 16'h0002));
        drive_level(12'h100);
        chk({15'h0000, comparator_pin_out}, {15'h0000, pol});
        rd(vcc_pkg::ADDR_CONTROL, cfg | 16'h0003);
        wr(vcc_pkg::ADDR_CONTROL, cfg | 16'h0003);
        rd(vcc_pkg::ADDR_CONTROL, cfg);
    endtask : t_edges
    task automatic t_irq;
        wr(vcc_pkg::ADDR_CONTROL, 16'h04C0);
        wr(vcc_pkg::ADDR_IRQ_STATUS, 16'h0003);
        wr(vcc_pkg::ADDR_IRQ_MASK, 16'h0001);
        drive_level(12'hC00);
        chk({14'h0000, comparator_irq, irq}, 16'h0002);
        rd(vcc_pkg::ADDR_IRQ_STATUS, 16'h0002);
        wr(vcc_pkg::ADDR_IRQ_MASK, 16'h0003);
        #1;
        chk({15'h0000, irq}, 16'h0001);
        rd(vcc_pkg::ADDR_IRQ_MASK, 16'h0003);
        wr(vcc_pkg::ADDR_CONTROL, 16'h04C2);
        wr(vcc_pkg::ADDR_IRQ_STATUS, 16'h0002);
        #1;
        chk({14'h0000, comparator_irq, irq}, 16'h0000);
        wr(vcc_pkg::ADDR_CONTROL, 16'h0080);
        drive_level(12'h100);
        drive_level(12'hC00);
        rd(vcc_pkg::ADDR_CONTROL, 16'h0080);
        chk({15'h0000, comparator_pin_out}, 16'h0000);
    endtask : t_irq

    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_fields();
        t_edges(1'b0);
        t_edges(1'b1);
        t_irq();
        complete_run();
    end
endmodule : tb_vcc_top

// file: dv/vcc_analog_model.sv
// Behavioural model of the analog comparator core and its negative-input multiplexer
`timescale 1ns/1ps
module vcc_analog_model (
    input  vcc_pkg::vcc_analog_ctrl_t ctrl,
    input  wire logic [11:0]          pos_level,
    output logic                      result
);
    // ==========================================================================
    // Negative-input sources, in converter counts
    localparam int HALF_SUPPLY = 2048;
    localparam int CHANNEL_3   = 1000;
    localparam int FIRST_DAC   = 3000;
    int neg;
    int hyst;
    initial result = 1'b0;
    always @(ctrl or pos_level) begin
        case (ctrl.negative_input_select)
            vcc_pkg::NEG_HALF_SUPPLY:   neg = HALF_SUPPLY;
            vcc_pkg::NEG_CHANNEL_THREE: neg = CHANNEL_3;
            vcc_pkg::NEG_FIRST_DAC:     neg = FIRST_DAC;
            default:                    neg = 4095;
        endcase
        hyst = ctrl.hysteresis_on ? 4 : 0;
        if (!ctrl.comparator_on) begin
            result = 1'b0;
        end else if (int'(pos_level) > neg + hyst) begin
            result = 1'b1;
        end else if (int'(pos_level) + hyst < neg) begin
            result = 1'b0;
        end
    end
endmodule : vcc_analog_model

// file: rtl/vcc_edge_detect.sv
// Synchroniser and edge detector for the analog comparator result
`timescale 1ns/1ps
module vcc_edge_detect (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    vcc_pkg::vcc_edge_state_t s_q;
    vcc_pkg::vcc_edge_state_t s_d;

    always_comb begin
        s_d       = s_q;
        s_d.sync  = {s_q.sync[0], async_in};
        s_d.prev  = s_q.sync[1];
        s_d.valid = enable;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Edges only count once the previous sample was taken while enabled
    assign level = s_q.sync[1];
    assign rise  = enable && s_q.valid && s_q.sync[1] && !s_q.prev;
    assign fall  = enable && s_q.valid && !s_q.sync[1] && s_q.prev;

endmodule : vcc_edge_detect

// file: rtl/vcc_pkg.sv
// Package of constants and carrier types for the comparator control block
package vcc_pkg;

    // ==========================================================================
    // Register map
    localparam logic [7:0]  ADDR_CONTROL     = 8'h00;
    localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h08;
    localparam logic [15:0] CONTROL_RESET    = 16'h0000;
    localparam logic [15:0] CONTROL_WR_MASK  = 16'h07FC;

    // ==========================================================================
    // Field positions of the control register
    localparam int BIT_COMPARATOR_ON   = 10;
    localparam int BIT_NEG_SEL_LO      = 8;
    localparam int BIT_ROUTING_LO      = 6;
    localparam int BIT_OUTPUT_POLARITY = 5;
    localparam int BIT_SPEED_LO        = 3;
    localparam int BIT_HYSTERESIS_ON   = 2;
    localparam int BIT_RISING_FLAG     = 1;
    localparam int BIT_FALLING_FLAG    = 0;

    // ==========================================================================
    // Field encodings
    localparam logic [1:0] NEG_HALF_SUPPLY    = 2'h0;
    localparam logic [1:0] NEG_CHANNEL_THREE  = 2'h1;
    localparam logic [1:0] NEG_FIRST_DAC      = 2'h2;
    localparam logic [1:0] ROUTE_PIN          = 2'h2;
    localparam logic [1:0] ROUTE_IRQ          = 2'h3;
    localparam logic [1:0] SPEED_STANDARD     = 2'h0;
    localparam logic [1:0] SPEED_FAST         = 2'h3;

    // ==========================================================================
    // Carrier types
    typedef struct packed {
        logic       comparator_on;
        logic [1:0] negative_input_select;
        logic       hysteresis_on;
        logic       fast_response;
    } vcc_analog_ctrl_t;

    typedef struct packed {
        logic [1:0] sync;
        logic       prev;
        logic       valid;
    } vcc_edge_state_t;

endpackage : vcc_pkg

// file: rtl/vcc_top.sv
// Comparator control register, edge flags, output routing and interrupt
//
// Behaviour
// - Bit 10 turns the comparator on/off
// - Bits 9:8 pick negative input source
// - Bits 7:6 route result to pin or IRQ
// - Bit 5 inverts the comparator output polarity
// - Bits 4:3 select standard or fast response
// - Bit 2 enables about 7.5 mV hysteresis
// - Sixteen-bit memory-mapped control register
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module vcc_top (
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic [7:0]                 addr,
    input  wire logic [15:0]                wdata,
    input  wire logic                       wr_en,
    input  wire logic                       rd_en,
    output logic      [15:0]                rdata,
    input  wire logic                       analog_result,
    output vcc_pkg::vcc_analog_ctrl_t       analog_ctrl,
    output logic                            comparator_pin_out,
    output logic                            comparator_irq,
    output logic                            irq
);
    // ==========================================================================
    // State
    typedef struct packed {
        logic [15:0] control;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic [15:0] rdata;
        logic        pin_out;
    } vcc_state_t;

    vcc_state_t s_q;
    vcc_state_t s_d;

    logic raw_level;
    logic raw_rise;
    logic raw_fall;
    logic cmp_level;
    logic cmp_rise;
    logic cmp_fall;
    logic polarity;
    logic routed_irq;

    // ==========================================================================
    // Comparator result conditioning
    vcc_edge_detect u_edge (
        .core_clk (core_clk),
        .rst      (rst),
        .enable   (s_q.control[vcc_pkg::BIT_COMPARATOR_ON]),
        .async_in (analog_result),
        .level    (raw_level),
        .rise     (raw_rise),
        .fall     (raw_fall)
    );

    assign polarity  = s_q.control[vcc_pkg::BIT_OUTPUT_POLARITY];
    assign cmp_level = raw_level ^ polarity;
    assign cmp_rise  = polarity ? raw_fall : raw_rise;
    assign cmp_fall  = polarity ? raw_rise : raw_fall;

    // ==========================================================================
    // Next state
    always_comb begin
        logic [15:0] wr_clear;
        logic        ctl_wr;
        logic        st_wr;
        wr_clear = 16'h0000;
        ctl_wr   = wr_en && (addr == vcc_pkg::ADDR_CONTROL);
        st_wr    = wr_en && (addr == vcc_pkg::ADDR_IRQ_STATUS);
        s_d      = s_q;

        if (ctl_wr) begin
            s_d.control = (s_q.control & ~vcc_pkg::CONTROL_WR_MASK)
                        | (wdata & vcc_pkg::CONTROL_WR_MASK);
            wr_clear    = wdata;
        end

        // Set wins over a same-cycle write-one clear
        if (wr_clear[vcc_pkg::BIT_RISING_FLAG]) begin
            s_d.control[vcc_pkg::BIT_RISING_FLAG] = 1'b0;
        end
        if (cmp_rise) begin
            s_d.control[vcc_pkg::BIT_RISING_FLAG] = 1'b1;
        end
        if (wr_clear[vcc_pkg::BIT_FALLING_FLAG]) begin
            s_d.control[vcc_pkg::BIT_FALLING_FLAG] = 1'b0;
        end
        if (cmp_fall) begin
            s_d.control[vcc_pkg::BIT_FALLING_FLAG] = 1'b1;
        end

        // Interrupt status mirrors the edge events, write-one clear
        if (st_wr) begin
            s_d.irq_status = s_q.irq_status & ~wdata[1:0];
        end
        s_d.irq_status = s_d.irq_status | {cmp_rise, cmp_fall};

        if (wr_en && (addr == vcc_pkg::ADDR_IRQ_MASK)) begin
            s_d.irq_mask = wdata[1:0];
        end

        s_d.pin_out = s_q.control[vcc_pkg::BIT_COMPARATOR_ON]
                   && (s_q.control[vcc_pkg::BIT_ROUTING_LO +: 2] == vcc_pkg::ROUTE_PIN)
                   && cmp_level;

        s_d.rdata = 16'h0000;
        if (rd_en) begin
            case (addr)
                vcc_pkg::ADDR_CONTROL:    s_d.rdata = s_q.control;
                vcc_pkg::ADDR_IRQ_STATUS: s_d.rdata = {14'h0000, s_q.irq_status};
                vcc_pkg::ADDR_IRQ_MASK:   s_d.rdata = {14'h0000, s_q.irq_mask};
                default:                  s_d.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q         <= '0;
            s_q.control <= vcc_pkg::CONTROL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================================
    // Outputs
    assign routed_irq = (s_q.control[vcc_pkg::BIT_ROUTING_LO +: 2] == vcc_pkg::ROUTE_IRQ)
                     && (s_q.control[vcc_pkg::BIT_RISING_FLAG]
                         || s_q.control[vcc_pkg::BIT_FALLING_FLAG]);

    assign rdata                             = s_q.rdata;
    assign comparator_pin_out                = s_q.pin_out;
    assign comparator_irq                    = routed_irq;
    assign irq                               = |(s_q.irq_status & s_q.irq_mask);
    assign analog_ctrl = '{
        comparator_on: s_q.control[vcc_pkg::BIT_COMPARATOR_ON],
        negative_input_select: s_q.control[vcc_pkg::BIT_NEG_SEL_LO +: 2],
        hysteresis_on: s_q.control[vcc_pkg::BIT_HYSTERESIS_ON],
        fast_response: (s_q.control[vcc_pkg::BIT_SPEED_LO +: 2] == vcc_pkg::SPEED_FAST)
    };

    // ==========================================================================
    // Checks
    property p_rise_sets;
        @(posedge core_clk) disable iff (rst)
        cmp_rise |=> s_q.control[1];
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rise flag not set");

    property p_fall_sets;
        @(posedge core_clk) disable iff (rst)
        cmp_fall |=> s_q.control[0];
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("fall flag not set");

    property p_rise_hold;
        @(posedge core_clk) disable iff (rst)
        (s_q.control[1] && !(wr_en && addr == vcc_pkg::ADDR_CONTROL && wdata[1]))
        |=> s_q.control[1];
    endproperty
    a_rise_hold: assert property (p_rise_hold) else $error("rise flag lost");

    property p_fall_clear;
        @(posedge core_clk) disable iff (rst)
        (wr_en && addr == vcc_pkg::ADDR_CONTROL && wdata[0] && !cmp_fall)
        |=> !s_q.control[0];
    endproperty
    a_fall_clear: assert property (p_fall_clear) else $error("fall flag not cleared");

    property p_ctrl_write;
        @(posedge core_clk) disable iff (rst)
        (wr_en && addr == vcc_pkg::ADDR_CONTROL)
        |=> s_q.control[10:2] == $past(wdata[10:2]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control not stored");

    property p_enable_out;
        @(posedge core_clk) disable iff (rst)
        (wr_en && addr == vcc_pkg::ADDR_CONTROL)
        |=> analog_ctrl.comparator_on == $past(wdata[10]);
    endproperty
    a_enable_out: assert property (p_enable_out) else $error("enable not applied");

    property p_pin_route;
        @(posedge core_clk) disable iff (rst)
        (s_q.control[7:6] != vcc_pkg::ROUTE_PIN) ##1
        (s_q.control[7:6] != vcc_pkg::ROUTE_PIN) |-> !comparator_pin_out;
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("pin driven when unrouted");

    // An edge seen while routed to the interrupt must raise the request
    property p_irq_route;
        @(posedge core_clk) disable iff (rst)
        ((cmp_rise || cmp_fall)
         && (s_q.control[vcc_pkg::BIT_ROUTING_LO +: 2] == vcc_pkg::ROUTE_IRQ)
         && !(wr_en && addr == vcc_pkg::ADDR_CONTROL))
        |=> comparator_irq;
    endproperty
    a_irq_route: assert property (p_irq_route) else $error("bad comparator irq");

    property p_read_ctrl;
        @(posedge core_clk) disable iff (rst)
        (rd_en && addr == vcc_pkg::ADDR_CONTROL) |=> rdata == $past(s_q.control);
    endproperty
    a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong");

    c_rise: cover property (@(posedge core_clk) disable iff (rst) cmp_rise);
    c_fall: cover property (@(posedge core_clk) disable iff (rst) cmp_fall);
    c_irq:  cover property (@(posedge core_clk) disable iff (rst) comparator_irq);
    c_pin:  cover property (@(posedge core_clk) disable iff (rst) comparator_pin_out);

endmodule : vcc_top
